// >>> rtl/dacc_cfg.svh
// Summary of operation
// RL1: Enable bit one turns the converter on, zero turns it off.
// RL2: While enabled, each data register write launches a conversion at once; here writes during DACC_STARTUP wait and merge into one conversion.
// RL3: While disabled, a data write only stores the value.
// RL4: Setting enable launches conversion of the value stored meanwhile.
// RL5: Control bit 6 turns on the pin buffer and drives the pin.
// RL6: Internal comparator and ADC see the output whenever the converter is enabled; here only in DACC_RUN, not during start-up.
// RL7: Keep-running bit 7 with clock present keeps everything running in standby.
// RL8: Without keep-running, standby stops conversion and powers converter and buffer down.
// RL9: Leaving standby re-enables converter, buffer if set, then waits start-up time.
// RL10: Power-down sleep disables converter and buffer regardless of keep-running.
// RL11: Halted debug leaves converter state and output untouched.
// RL12: Control register at offset 0, reset 0, bits 0, 6, 7 read-write.
// RL13: Data register at offset 1, 8 bits, read-write, reset 0, converted value.
// RL14: Software sets reference, consumer, data, and only then the enable bit.
// RL15: Control bits 5 to 1 read as zero and ignore writes.
`ifndef DACC_CFG_SVH
`define DACC_CFG_SVH
`define DACC_CTRL_OFFS      8'h00
`define DACC_DATA_OFFS      8'h01
`define DACC_CTRL_RESET     8'h00
`define DACC_DATA_RESET     8'h00
`define DACC_EN_BIT         0
`define DACC_BUF_BIT        6
`define DACC_STBY_BIT       7
`define DACC_CTRL_MASK      8'hc1
`define DACC_STARTUP_NS     1000
`define DACC_CLK_PERIOD_NS  25
`define DACC_STARTUP_CYC    ((`DACC_STARTUP_NS + `DACC_CLK_PERIOD_NS - 1) / `DACC_CLK_PERIOD_NS)
`endif

// >>> rtl/dacc_pkg.sv
package dacc_pkg;
  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dacc_bus_req_t;

  // Analog macro controls
  typedef struct packed {
    logic       core_on;
    logic       pin_buf_on;
    logic       internal_valid;
    logic       convert;
    logic [7:0] code;
  } dacc_ana_t;

  typedef enum logic [2:0] {
    DACC_OFF     = 3'b001,
    DACC_STARTUP = 3'b010,
    DACC_RUN     = 3'b100
  } dacc_state_t;
endpackage

// >>> rtl/dacc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dacc_cfg.svh"
module dacc_top (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  input  wire dacc_pkg::dacc_bus_req_t bus_in,
  input  wire logic                   standby_in,
  input  wire logic                   power_down_in,
  input  wire logic                   clk_present_in,
  input  wire logic                   debug_halt_in,
  output logic [7:0]                  rdata_out,
  output var dacc_pkg::dacc_ana_t     ana_out
);
  import dacc_pkg::*;

  localparam logic [5:0] STARTUP_CYC = 6'(`DACC_STARTUP_CYC);

  // Offset match shared by the write and read decoders
  function automatic logic addr_hit(input dacc_bus_req_t req, input logic [7:0] offs);
    return (req.addr == offs);
  endfunction

  logic [7:0]  ctrl_reg, ctrl_next;
  logic [7:0]  data_reg, data_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [1:0]  stby_sync_reg, pd_sync_reg, clk_sync_reg;
  dacc_state_t state_reg, state_next;
  logic [5:0]  cnt_reg, cnt_next;
  logic        pend_reg, pend_next;
  dacc_ana_t   ana_reg, ana_next;
  logic        wr_ctrl, wr_data, sleep_stop, en_now;

  // Sleep inputs come from the power manager domain; debug halt is ignored
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      stby_sync_reg <= 2'b00;
      pd_sync_reg   <= 2'b00;
      clk_sync_reg  <= 2'b00;
    end else begin
      stby_sync_reg <= {stby_sync_reg[0], standby_in};
      pd_sync_reg   <= {pd_sync_reg[0], power_down_in};
      clk_sync_reg  <= {clk_sync_reg[0], clk_present_in};
    end
  end

  // Address decode and register updates
  always_comb begin
    wr_ctrl = 1'b0;
    wr_data = 1'b0;
    if (bus_in.wr && addr_hit(bus_in, `DACC_CTRL_OFFS)) begin
      wr_ctrl = 1'b1;
    end else if (bus_in.wr && addr_hit(bus_in, `DACC_DATA_OFFS)) begin
      wr_data = 1'b1;
    end
    ctrl_next = wr_ctrl ? (bus_in.wdata & `DACC_CTRL_MASK) : ctrl_reg; // RL12 RL15
    data_next = wr_data ? bus_in.wdata : data_reg; // RL13
    rdata_next = 8'h00; // Unmapped reads return zero
    if (bus_in.rd && addr_hit(bus_in, `DACC_CTRL_OFFS)) begin
      rdata_next = ctrl_reg; // RL15
    end else if (bus_in.rd && addr_hit(bus_in, `DACC_DATA_OFFS)) begin
      rdata_next = data_reg;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg  <= `DACC_CTRL_RESET;
      data_reg  <= `DACC_DATA_RESET;
      rdata_reg <= 8'h00;
    end else begin
      ctrl_reg  <= ctrl_next;
      data_reg  <= data_next;
      rdata_reg <= rdata_next;
    end
  end

  // Converter sequencing; debug_halt_in deliberately unused
  always_comb begin
    en_now = ctrl_next[`DACC_EN_BIT]; // RL1
    // Power-down always stops; standby only without keep-running and clock
    sleep_stop = pd_sync_reg[1] || // RL10
                 (stby_sync_reg[1] &&
                  !(ctrl_reg[`DACC_STBY_BIT] && clk_sync_reg[1])); // RL7 RL8
    state_next = state_reg;
    cnt_next   = cnt_reg;
    pend_next  = pend_reg;
    ana_next   = ana_reg;
    ana_next.convert = 1'b0;
    ana_next.code    = data_next; // RL13
    case (state_reg)
      DACC_OFF: begin
        // Enable launches conversion of whatever was stored while off
        if (en_now && !ctrl_reg[`DACC_EN_BIT] && !sleep_stop) begin
          state_next = DACC_RUN;
          ana_next.convert = 1'b1; // RL4
        end else if (en_now && !sleep_stop) begin
          // Waking from a sleep stop
          state_next = DACC_STARTUP; // RL9
          cnt_next   = STARTUP_CYC;
          pend_next  = 1'b1;
        end
      end
      DACC_STARTUP: begin
        if (!en_now || sleep_stop) begin
          state_next = DACC_OFF;
        end else if (cnt_reg <= 6'd1) begin
          state_next = DACC_RUN;
          ana_next.convert = pend_reg || wr_data; // RL9
          pend_next = 1'b0;
        end else begin
          cnt_next  = cnt_reg - 6'd1;
          pend_next = pend_reg || wr_data;
        end
      end
      DACC_RUN: begin
        if (!en_now || sleep_stop) begin
          state_next = DACC_OFF; // RL1 RL8 RL10
        end else if (wr_data) begin
          ana_next.convert = 1'b1; // RL2
        end
      end
      default: state_next = DACC_OFF;
    endcase
    // Data writes while off only store the value
    if (state_next == DACC_OFF) begin
      ana_next.convert = 1'b0; // RL3
    end
    ana_next.core_on        = (state_next != DACC_OFF); // RL9
    ana_next.internal_valid = (state_next == DACC_RUN); // RL6
    ana_next.pin_buf_on     = (state_next != DACC_OFF) &&
                              ctrl_next[`DACC_BUF_BIT]; // RL5
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= DACC_OFF;
      cnt_reg   <= 6'd0;
      pend_reg  <= 1'b0;
      ana_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pend_reg  <= pend_next;
      ana_reg   <= ana_next;
    end
  end

  // Outputs straight from flip-flops
  assign rdata_out = rdata_reg;
  assign ana_out   = ana_reg; // RL11
endmodule // dacc_top
`default_nettype wire

// >>> bench/dacc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dacc_top_assertions (
  input wire logic                    mclk_in,
  input wire logic                    rst_in,
  input wire dacc_pkg::dacc_bus_req_t bus_in,
  input wire logic                    standby_in,
  input wire logic                    power_down_in,
  input wire logic                    clk_present_in,
  input wire logic                    debug_halt_in,
  input wire logic [7:0]              rdata_out,
  input wire dacc_pkg::dacc_ana_t     ana_out
);
  import dacc_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Register writes seen on the bus
  sequence s_wd; bus_in.wr && bus_in.addr == 8'h01; endsequence
  sequence s_wc; bus_in.wr && bus_in.addr == 8'h00; endsequence
  AST_WR_RUN: assert property (s_wd ##0 ana_out.internal_valid |=>
    ana_out.convert && ana_out.code == $past(bus_in.wdata)) else $error("No conversion");
  AST_WR_OFF: assert property (s_wd ##0 !ana_out.core_on |=> !ana_out.convert)
    else $error("Conversion while off");
  AST_EN: assert property (s_wc ##0 bus_in.wdata[0] && !ana_out.core_on
    && !standby_in && !power_down_in |=> ana_out.convert && ana_out.internal_valid)
    else $error("Enable did not convert");
  AST_DIS: assert property (s_wc ##0 !bus_in.wdata[0] |=> !ana_out.core_on)
    else $error("Disable ignored");
  AST_BUF: assert property (s_wc ##0 (bus_in.wdata & 8'h41) == 8'h41
    && ana_out.internal_valid |=> ana_out.pin_buf_on) else $error("Buffer off");
  AST_PD: assert property (power_down_in [*5] |-> !ana_out.core_on && !ana_out.pin_buf_on)
    else $error("Power down ignored");
  AST_STBY: assert property ((standby_in && !clk_present_in) [*5] |-> !ana_out.core_on)
    else $error("Standby ignored");
  // Start-up wait sits between the core turning on after a sleep stop and the first conversion
  AST_START: assert property ($rose(ana_out.core_on) && !ana_out.internal_valid
    |-> ##[39:41] ana_out.convert) else $error("Bad start-up time");
  AST_RSV: assert property (bus_in.rd && bus_in.addr == 8'h00 |=> rdata_out[5:1] == 5'h00)
    else $error("Reserved bits set");
endmodule // dacc_top_assertions
`default_nettype wire

// >>> bench/dacc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dacc_top_tb;
  import dacc_pkg::*;
  logic          mclk_in = 1'b0, rst_in = 1'b1, debug_halt_in = 1'b0;
  logic          standby_in = 1'b0, power_down_in = 1'b0, clk_present_in = 1'b1;
  dacc_bus_req_t bus_in = '0;
  logic [7:0]    rdata_out;
  dacc_ana_t     ana_out;
  int            err_count = 0, samples_checked = 0;
  // Rows: 01 read or 00 write, address, data, expected read
  logic [31:0] rows [8] = '{32'h01000000, 32'h01010000, 32'h00015a00, 32'h0101005a,
    32'h0000be00, 32'h01000080, 32'h01070000, 32'h00000000};
  dacc_top i_dut (.mclk_in, .rst_in, .bus_in, .standby_in, .power_down_in,
    .clk_present_in, .debug_halt_in, .rdata_out, .ana_out);
  always #12.5 mclk_in = ~mclk_in;
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Only the three level flags; code is free
  task automatic top(input logic [2:0] e);
    chk({ana_out[11:9], 9'h000}, {e, 9'h000});
  endtask
  // One strobe cycle, then settle past the answering edge
  task automatic acc(input logic [7:0] r, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in) bus_in <= {a, d, r == 8'h00, r == 8'h01};
    @(posedge mclk_in) bus_in <= '0;
    #1;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic stop_test;
    $display("errors=%0d checks=%0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      acc(rows[i][31:24], rows[i][23:16], rows[i][15:8]);
      if (rows[i][24]) chk({4'h0, rdata_out}, {4'h0, rows[i][7:0]});
    end
    // Data first, enable last; the code follows the stored value while off
    acc(8'h00, 8'h01, 8'h3c);
    chk(ana_out, 12'h03c);
    acc(8'h00, 8'h00, 8'h01);
    chk(ana_out, 12'hb3c);
    acc(8'h00, 8'h01, 8'ha5);
    chk(ana_out, 12'hba5);
    @(posedge mclk_in) debug_halt_in <= 1'b1;
    wait_n(3);
    chk(ana_out, 12'haa5);
    acc(8'h00, 8'h00, 8'h41);
    top(3'h7);
    // Clock absent too, so standby must stop the core
    @(posedge mclk_in) {standby_in, clk_present_in} <= 2'b10;
    wait_n(6);
    top(3'h0);
    @(posedge mclk_in) {standby_in, clk_present_in} <= 2'b01;
    wait_n(5);
    top(3'h6);
    wait_n(45);
    top(3'h7);
    acc(8'h00, 8'h00, 8'hc1);
    @(posedge mclk_in) standby_in <= 1'b1;
    wait_n(6);
    top(3'h7);
    @(posedge mclk_in) power_down_in <= 1'b1;
    wait_n(6);
    top(3'h0);
    @(posedge mclk_in) {standby_in, power_down_in} <= 2'b00;
    wait_n(50);
    acc(8'h00, 8'h00, 8'h00);
    top(3'h0);
    // Mid-run reset while running must clear registers and outputs
    acc(8'h00, 8'h01, 8'h77);
    acc(8'h00, 8'h00, 8'hc1);
    @(posedge mclk_in) rst_in <= 1'b1;
    wait_n(4);
    chk(ana_out, 12'h000);
    @(posedge mclk_in) rst_in <= 1'b0;
    acc(8'h01, 8'h00, 8'h00);
    chk({4'h0, rdata_out}, 12'h000);
    acc(8'h01, 8'h01, 8'h00);
    chk({4'h0, rdata_out}, 12'h000);
    acc(8'h00, 8'h01, 8'h5a);
    acc(8'h01, 8'h01, 8'h00);
    chk({4'h0, rdata_out}, 12'h05a);
    // Read data stand for one cycle only
    wait_n(1);
    chk({4'h0, rdata_out}, 12'h000);
    stop_test;
  end
  // Watchdog well past the fewer than two hundred cycles of the sequence
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
endmodule // dacc_top_tb
bind dacc_top dacc_top_assertions i_chk (.mclk_in, .rst_in, .bus_in, .standby_in,
  .power_down_in, .clk_present_in, .debug_halt_in, .rdata_out, .ana_out);
`default_nettype wire
